// ---- strap_decode_and_led_polarity.sv ----
// Strap decoder, configuration hold and indicator function/polarity output stage.
// Assumes strap mode codes come from the pad comparators (asynchronous to sys_clk),
// and registers are reached through a simple word write/read port on sys_clk.
// Operation
// - Pin1 strap gives advertise select, tx skew2
// - Pin0 strap gives mirror, serial MAC enable
// - Select 0 advertises 10, 100, 1000
// - Select 1 advertises 100 and 1000 only
// - Three tx skew bits choose tx delay
// - Three rx skew bits choose rx delay
// - Four indicators, functions via control register
// - Modes 1-3 make indicator active high
// - Mode 4 makes indicator active low
// - Sample straps at hardware reset release
// - Software reset reloads latched strap values
// - Pin2 strap gives tx skew bits 1:0
// - General pins give receive skew bits
`timescale 1ns/1ps
`default_nettype none

module strap_decode_and_led_polarity #(
   parameter int NUM_IND = strap_cfg_pkg::NUM_IND
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic softReset,
   input wire logic [1:0] strapInd0,
   input wire logic [1:0] strapInd1,
   input wire logic [1:0] strapInd2,
   input wire logic [1:0] strapInd3,
   input wire logic [1:0] strapGp0,
   input wire logic [1:0] strapGp1,
   input wire logic regWrite,
   input wire logic [5:0] regAddr,
   input wire logic [15:0] regWdata,
   output logic [15:0] regRdata,
   input wire logic linkUp,
   input wire logic activity,
   input wire logic [1:0] speedCode,
   output logic advertiseSelect,
   output logic [2:0] advertiseSpeeds,
   output logic [2:0] txSkewSel,
   output logic [2:0] rxSkewSel,
   output logic mirrorEnable,
   output logic serialMacEnable,
   output logic indicator_pin_0,
   output logic indicator_pin_1,
   output logic indicator_pin_2,
   output logic indicator_pin_3
);

   // ----------------------------------------------------------------------
   // Strap synchronisers
   // ----------------------------------------------------------------------
   logic [11:0] strapMeta_r;
   logic [11:0] strapSync_r;
   logic [1:0] latchDone_r;

   // Two stages before any decode; pads are not on sys_clk
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         strapMeta_r <= 12'h000;
         strapSync_r <= 12'h000;
      end else begin
         strapMeta_r <= {strapGp1, strapGp0, strapInd3, strapInd2, strapInd1, strapInd0};
         strapSync_r <= strapMeta_r;
      end
   end

   // ----------------------------------------------------------------------
   // Strap latch
   // ----------------------------------------------------------------------
   logic [11:0] strapLatch_r;

   // Wait two edges after release so the synchroniser holds real pad levels
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         latchDone_r <= 2'h0;
      end else if (latchDone_r != strap_cfg_pkg::LATCH_DONE) begin
         latchDone_r <= latchDone_r + 2'h1;
      end
   end

   // Captured once per hardware reset; software reset never resamples
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         strapLatch_r <= 12'h000;
      end else if (latchDone_r == strap_cfg_pkg::LATCH_STEP) begin
         strapLatch_r <= strapSync_r;
      end
   end

   // ----------------------------------------------------------------------
   // Decode into configuration flops
   // ----------------------------------------------------------------------
   logic [1:0] ind0Mode, ind1Mode, ind2Mode, ind3Mode, gp0Mode, gp1Mode;
   assign ind0Mode = strapLatch_r[1:0];
   assign ind1Mode = strapLatch_r[3:2];
   assign ind2Mode = strapLatch_r[5:4];
   assign ind3Mode = strapLatch_r[7:6];
   assign gp0Mode = strapLatch_r[9:8];
   assign gp1Mode = strapLatch_r[11:10];

   logic reload;
   logic cfgLoaded_r;

   // One load per hardware reset; a reload held high would swallow every later configuration four write
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfgLoaded_r <= 1'b0;
      end else if (latchDone_r == strap_cfg_pkg::LATCH_DONE) begin
         cfgLoaded_r <= 1'b1;
      end
   end

   assign reload = ((latchDone_r == strap_cfg_pkg::LATCH_DONE) && !cfgLoaded_r) || softReset;

   logic [9:0] cfg_r;
   logic [9:0] cfg_nxt;

   // Mode n maps to pair value n-1; mode code is already that binary pair
   always_comb begin
      cfg_nxt[9] = ind1Mode[1];
      cfg_nxt[8] = ind1Mode[0];
      cfg_nxt[7:6] = ind2Mode;
      cfg_nxt[5] = ind0Mode[1];
      cfg_nxt[4] = ind0Mode[0];
      cfg_nxt[3:2] = gp1Mode;
      // Only modes 1 and 3 are legal here; the upper decision level decides
      cfg_nxt[1] = (gp0Mode >= strap_cfg_pkg::MODE3);
      cfg_nxt[0] = 1'b0;
   end

   // Held until the next reset event; software reset reloads it from the latch
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_r <= 10'h000;
      end else if (reload) begin
         cfg_r <= cfg_nxt;
      end
   end

   assign advertiseSelect = cfg_r[9];
   // Speeds advertised follow the select bit
   assign advertiseSpeeds = cfg_r[9] ? strap_cfg_pkg::ADV_NO10
                                     : strap_cfg_pkg::ADV_ALL;
   assign txSkewSel = {cfg_r[8], cfg_r[7:6]};
   assign rxSkewSel = {cfg_r[3:2], cfg_r[1]};

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [15:0] indFunc_r;
   logic [15:0] cfgFour_r;
   logic mirrorSw_r;

   // Function control defaults on any reset event
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         indFunc_r <= strap_cfg_pkg::IND_FUNC_RESET;
      end else if (softReset) begin
         indFunc_r <= strap_cfg_pkg::IND_FUNC_RESET;
      end else if (regWrite && regAddr == 6'(strap_cfg_pkg::INDICATOR_FUNCTION_CONTROL_OFS)) begin
         indFunc_r <= regWdata;
      end
   end

   // Mirror bit defaults from strap; bit 7 left for software to clear
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfgFour_r <= strap_cfg_pkg::CFG4_RESET;
         mirrorSw_r <= 1'b0;
      end else if (reload) begin
         cfgFour_r <= strap_cfg_pkg::CFG4_RESET;
         mirrorSw_r <= cfg_nxt[5];
      end else if (regWrite && regAddr == strap_cfg_pkg::CONFIGURATION_FOUR_OFS) begin
         cfgFour_r <= regWdata;
         mirrorSw_r <= regWdata[strap_cfg_pkg::CFG4_MIRROR_BIT];
      end
   end

   assign mirrorEnable = mirrorSw_r;
   assign serialMacEnable = cfg_r[4];

   // Read mux; unmapped offsets read zero
   always_comb begin
      regRdata = 16'h0000;
      if (regAddr == 6'(strap_cfg_pkg::INDICATOR_FUNCTION_CONTROL_OFS)) begin
         regRdata = indFunc_r;
      end else if (regAddr == strap_cfg_pkg::CONFIGURATION_FOUR_OFS) begin
         regRdata = {cfgFour_r[15:1], mirrorSw_r};
      end
   end

   // ----------------------------------------------------------------------
   // Indicator function select and polarity
   // ----------------------------------------------------------------------
   logic [3:0] activeLow;
   logic [3:0] funcOn;
   logic [3:0] indOut_r;

   assign activeLow = {ind3Mode == strap_cfg_pkg::MODE4, ind2Mode == strap_cfg_pkg::MODE4,
                       ind1Mode == strap_cfg_pkg::MODE4, ind0Mode == strap_cfg_pkg::MODE4};

   generate
      for (genvar i = 0; i < NUM_IND; i++) begin : g_ind
         logic [3:0] sel;
         assign sel = indFunc_r[i*4 +: 4];
         // Function logic works active high throughout
         always_comb begin
            unique case (sel)
               strap_cfg_pkg::FUNC_LINK: funcOn[i] = linkUp;
               strap_cfg_pkg::FUNC_ACT: funcOn[i] = activity;
               strap_cfg_pkg::FUNC_SPD1000: begin
                  funcOn[i] = linkUp && speedCode == strap_cfg_pkg::SPEED_1000;
               end
               strap_cfg_pkg::FUNC_SPD100: begin
                  funcOn[i] = linkUp && speedCode == strap_cfg_pkg::SPEED_100;
               end
               strap_cfg_pkg::FUNC_SPD10: begin
                  funcOn[i] = linkUp && speedCode == strap_cfg_pkg::SPEED_10;
               end
               strap_cfg_pkg::FUNC_ON: funcOn[i] = 1'b1;
               default: funcOn[i] = 1'b0; // Unused codes and FUNC_OFF are dark
            endcase
         end
         // Inversion last; during reset pins sit inactive-high-style low
         always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               indOut_r[i] <= 1'b0;
            end else begin
               indOut_r[i] <= funcOn[i] ^ activeLow[i];
            end
         end
      end
   endgenerate

   assign indicator_pin_0 = indOut_r[0];
   assign indicator_pin_1 = indOut_r[1];
   assign indicator_pin_2 = indOut_r[2];
   assign indicator_pin_3 = indOut_r[3];

endmodule

`default_nettype wire

// ---- strap_cfg_pkg.sv ----
// Constants for the strap decoder and indicator polarity block.
// Assumes strap levels arrive already quantised to a 2-bit mode code (0..3 = mode 1..4).
package strap_cfg_pkg;

   // ----------------------------------------------------------------------
   // Register offsets and field positions
   // ----------------------------------------------------------------------
   localparam logic [4:0] INDICATOR_FUNCTION_CONTROL_OFS = 5'h18;
   localparam logic [5:0] CONFIGURATION_FOUR_OFS = 6'h31;
   localparam int REG_ADDR_W = 6;
   localparam int REG_DATA_W = 16;
   localparam int CFG4_RXCTRL_BIT = 7;
   localparam int CFG4_MIRROR_BIT = 0;
   localparam int FUNC_SEL_W = 4;
   localparam int NUM_IND = 4;

   // ----------------------------------------------------------------------
   // Strap mode codes and defaults
   // ----------------------------------------------------------------------
   localparam logic [1:0] MODE1 = 2'h0;
   localparam logic [1:0] MODE3 = 2'h2;
   localparam logic [1:0] MODE4 = 2'h3;
   // Strap latch timing, in edges counted after reset release
   localparam logic [1:0] LATCH_STEP = 2'h2;
   localparam logic [1:0] LATCH_DONE = 2'h3;
   // Link speed codes on speedCode
   localparam logic [1:0] SPEED_1000 = 2'h2;
   localparam logic [1:0] SPEED_100 = 2'h1;
   localparam logic [1:0] SPEED_10 = 2'h0;
   localparam logic [15:0] IND_FUNC_RESET = 16'h0000;
   localparam logic [15:0] CFG4_RESET = 16'h0080;

   // Indicator function selector codes
   localparam logic [3:0] FUNC_LINK = 4'h0;
   localparam logic [3:0] FUNC_ACT = 4'h1;
   localparam logic [3:0] FUNC_SPD1000 = 4'h2;
   localparam logic [3:0] FUNC_SPD100 = 4'h3;
   localparam logic [3:0] FUNC_SPD10 = 4'h4;
   localparam logic [3:0] FUNC_ON = 4'hE;
   localparam logic [3:0] FUNC_OFF = 4'hF;

   // Advertised speed set: bit2 = 1000, bit1 = 100, bit0 = 10
   localparam logic [2:0] ADV_ALL = 3'h7;
   localparam logic [2:0] ADV_NO10 = 3'h6;

endpackage

// ---- strap_board.sv ----
// Board strap resistors seen at the strap pins.
// Assumes the bench raises hold around reset release.
`timescale 1ns/1ps
`default_nettype none
module strap_board (
   input wire logic hold,
   input wire logic [1:0] base,
   output logic [1:0] sInd0,
   output logic [1:0] sInd1,
   output logic [1:0] sInd2,
   output logic [1:0] sInd3,
   output logic [1:0] sGp0,
   output logic [1:0] sGp1
);
   // Outside the latch window the pins carry other traffic; show the inverse
   // The receive control strap is not routed here; the board keeps it at mode 3,
   // which also leaves autoneg disable at zero for gigabit use
   logic [1:0] v;
   always_comb begin
      v = hold ? 2'h0 : 2'h3;
      sInd0 = base ^ v;
      sInd1 = (base + 2'h1) ^ v;
      sInd2 = (base + 2'h2) ^ v;
      sInd3 = (base + 2'h3) ^ v;
      sGp0 = {base[0], 1'b0} ^ v;
      sGp1 = ~base ^ v;
   end
endmodule
`default_nettype wire

// ---- strap_decode_and_led_polarity_sva.sv ----
// Checker for the strap decoder ports.
// Assumes straps stay steady for four cycles after reset release.
`timescale 1ns/1ps
`default_nettype none
module strap_chk (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic softReset,
   input wire logic [1:0] strapInd0,
   input wire logic [1:0] strapInd1,
   input wire logic [1:0] strapInd2,
   input wire logic [1:0] strapInd3,
   input wire logic [1:0] strapGp0,
   input wire logic [1:0] strapGp1,
   input wire logic regWrite,
   input wire logic [5:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic [15:0] regRdata,
   input wire logic advertiseSelect,
   input wire logic [2:0] advertiseSpeeds,
   input wire logic [2:0] txSkewSel,
   input wire logic [2:0] rxSkewSel,
   input wire logic mirrorEnable,
   input wire logic serialMacEnable,
   input wire logic indicator_pin_0,
   input wire logic indicator_pin_1,
   input wire logic indicator_pin_2,
   input wire logic indicator_pin_3
);
   logic [3:0] age_r;
   logic [11:0] cap_r;
   logic [3:0] actLow;
   logic [3:0] pins;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Age since reset; capture straps only while the device latches them
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) age_r <= 4'h0;
      else if (age_r != 4'hF) age_r <= age_r + 4'h1;
   end
   always_ff @(posedge sys_clk) begin
      if (age_r < 4'h4) cap_r <= {strapInd0, strapInd1, strapInd2, strapInd3, strapGp0, strapGp1};
   end
   assign actLow = {cap_r[5:4] == 2'h3, cap_r[7:6] == 2'h3, cap_r[9:8] == 2'h3, cap_r[11:10] == 2'h3};
   assign pins = {indicator_pin_3, indicator_pin_2, indicator_pin_1, indicator_pin_0};
   AST_ADV_ALL: assert property (!advertiseSelect |-> advertiseSpeeds == 3'h7)
      else $error("speed set wrong, select low");
   AST_ADV_NO10: assert property (advertiseSelect |-> advertiseSpeeds == 3'h6)
      else $error("speed set wrong, select high");
   AST_PIN0: assert property (age_r == 4'hF |-> {mirrorEnable, serialMacEnable} == cap_r[11:10])
      else $error("pin 0 strap decode wrong");
   AST_PIN1: assert property (age_r == 4'hF |-> {advertiseSelect, txSkewSel[2]} == cap_r[9:8])
      else $error("pin 1 strap decode wrong");
   AST_TXSKEW: assert property (age_r == 4'hF |-> txSkewSel[1:0] == cap_r[7:6])
      else $error("tx skew low bits wrong");
   AST_RXSKEW: assert property (age_r == 4'hF |-> rxSkewSel == {cap_r[1:0], cap_r[3]})
      else $error("rx skew decode wrong");
   AST_ON: assert property (regWrite && regAddr == 6'h18 && regWdata == 16'hEEEE && !softReset |-> ##2 pins == ~actLow)
      else $error("forced-on level wrong");
   AST_OFF: assert property (regWrite && regAddr == 6'h18 && regWdata == 16'hFFFF && !softReset |-> ##2 pins == actLow)
      else $error("forced-off level wrong");
   AST_SOFT: assert property (softReset ##1 regAddr == 6'h18 |-> regRdata == 16'h0000)
      else $error("function control kept over soft reset");
   AST_UNMAP: assert property (regAddr != 6'h18 && regAddr != 6'h31 |-> regRdata == 16'h0000)
      else $error("unmapped read not zero");
endmodule
bind strap_decode_and_led_polarity strap_chk u_chk (.sys_clk, .sys_rst, .softReset, .strapInd0,
   .strapInd1, .strapInd2, .strapInd3, .strapGp0, .strapGp1, .regWrite, .regAddr, .regWdata,
   .regRdata, .advertiseSelect, .advertiseSpeeds, .txSkewSel, .rxSkewSel, .mirrorEnable,
   .serialMacEnable, .indicator_pin_0, .indicator_pin_1, .indicator_pin_2, .indicator_pin_3);
`default_nettype wire

// ---- strap_decode_and_led_polarity_bench.sv ----
// Bench for the strap decoder: every strap mode, forced indicators, soft reset.
// Assumes the board model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module strap_decode_and_led_polarity_bench;
   logic sys_clk = 1'b0, sys_rst = 1'b1, softReset = 1'b0, regWrite = 1'b0, hold = 1'b1;
   logic linkUp = 1'b0, activity = 1'b0;
   logic [1:0] speedCode = 2'h0;
   logic [5:0] regAddr = 6'h00;
   logic [15:0] regWdata = 16'h0000, regRdata;
   logic [1:0] base = 2'h0, s0, s1, s2, s3, g0, g1;
   logic advSel, mirror, serial;
   logic [2:0] speeds, tx, rx;
   logic [3:0] pins, pol;
   int n_fail = 0, compares = 0;
   always #20 sys_clk = ~sys_clk;
   strap_board u_board (.hold(hold), .base(base), .sInd0(s0), .sInd1(s1), .sInd2(s2),
      .sInd3(s3), .sGp0(g0), .sGp1(g1));
   strap_decode_and_led_polarity u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .softReset(softReset), .strapInd0(s0), .strapInd1(s1), .strapInd2(s2), .strapInd3(s3),
      .strapGp0(g0), .strapGp1(g1), .regWrite(regWrite), .regAddr(regAddr),
      .regWdata(regWdata), .regRdata(regRdata), .linkUp(linkUp), .activity(activity),
      .speedCode(speedCode), .advertiseSelect(advSel), .advertiseSpeeds(speeds), .txSkewSel(tx),
      .rxSkewSel(rx), .mirrorEnable(mirror), .serialMacEnable(serial),
      .indicator_pin_0(pins[0]), .indicator_pin_1(pins[1]), .indicator_pin_2(pins[2]),
      .indicator_pin_3(pins[3]));
   // ----------
   // Tasks
   // ----------
   task cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Write strobe lasts one cycle; pins follow one edge after it is taken
   task wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWrite <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask
   task rd(input logic [5:0] a, input logic [15:0] exp, input string what);
      @(posedge sys_clk);
      regAddr <= a;
      @(negedge sys_clk);
      cmp(regRdata, exp, what);
   endtask
   // Expected decode from the mode codes that were strapped
   task check_cfg(input logic [1:0] b);
      logic [1:0] c1;
      c1 = b + 2'h1;
      cmp({mirror, serial}, b, "mirror/serial");
      cmp({advSel, tx[2]}, c1, "select/tx2");
      cmp(speeds, c1[1] ? 3'h6 : 3'h7, "speeds");
      cmp(tx, {c1[0], b + 2'h2}, "tx skew");
      cmp(rx, {~b, b[0]}, "rx skew");
   endtask
   task print_verdict;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ----------
   // Main sequence
   // ----------
   initial begin
      for (int m = 0; m < 4; m++) begin
         @(posedge sys_clk);
         sys_rst <= 1'b1;
         hold <= 1'b1;
         base <= m[1:0];
         linkUp <= m[0];
         activity <= ~m[0];
         repeat (2) @(posedge sys_clk);
         sys_rst <= 1'b0;
         repeat (6) @(posedge sys_clk);
         hold <= 1'b0; // pins now toggle; latched copy must not follow
         repeat (12) @(posedge sys_clk);
         pol = {m[1:0] == 2'h0, m[1:0] == 2'h1, m[1:0] == 2'h2, m[1:0] == 2'h3};
         check_cfg(m[1:0]);
         rd(6'h18, strap_cfg_pkg::IND_FUNC_RESET, "function reset");
         rd(6'h31, strap_cfg_pkg::CFG4_RESET | {15'h0, m[1]}, "cfg4");
         rd(6'h3F, 16'h0000, "unmapped");
         wr(6'h18, 16'hEEEE);
         cmp({12'h0, pins}, {12'h0, ~pol}, "forced on");
         wr(6'h18, 16'hFFFF);
         cmp({12'h0, pins}, {12'h0, pol}, "forced off");
         wr(6'h18, 16'h0000);
         cmp({12'h0, pins}, {12'h0, linkUp ? ~pol : pol}, "link");
         // Activity and the three speed functions, one indicator each
         wr(6'h18, 16'h4321);
         for (int s = 0; s < 3; s++) begin
            speedCode <= s[1:0];
            repeat (3) @(posedge sys_clk);
            cmp({12'h0, pins}, {12'h0, pol ^ {linkUp && s == 0, linkUp && s == 1,
               linkUp && s == 2, activity}}, "functions");
         end
         // Software clears bit 7 and keeps the strapped mirror bit
         wr(6'h31, {15'h0, m[1]});
         rd(6'h31, {15'h0, m[1]}, "cfg4 bit 7 cleared");
         wr(6'h18, 16'hEEEE);
         softReset <= 1'b1;
         @(posedge sys_clk);
         softReset <= 1'b0;
         rd(6'h18, 16'h0000, "soft reset function");
         rd(6'h31, strap_cfg_pkg::CFG4_RESET | {15'h0, m[1]}, "soft reset cfg4");
         repeat (4) @(posedge sys_clk);
         check_cfg(m[1:0]);
         $display("test base %0d done", m);
      end
      print_verdict;
   end
endmodule
`default_nettype wire
